// File: dxv_core_model.sv
// Behavioural core that acknowledges lines on command, promptly or late
`timescale 1ns/100ps
`default_nettype none
module dxv_core_model (
   input wire logic clk,
   output logic core_ack,
   output logic [2:0] core_ack_line
);
   // Idle state; the line code is not held once released
   initial begin
      core_ack = 1'b0;
      core_ack_line = 3'h0;
   end
   // One acknowledge pulse after some idle cycles
   task automatic ack(input logic [2:0] line, input int late);
      repeat (late) @(posedge clk);
      @(posedge clk);
      #1;
      core_ack = 1'b1;
      core_ack_line = line;
      @(posedge clk);
      #1;
      core_ack = 1'b0;
      core_ack_line = ~line;
   endtask : ack
endmodule : dxv_core_model
`default_nettype wire

// File: dxv_group_pick.sv
// Lowest-index pending pick over one slice of the entry table
`timescale 1ns/100ps
`default_nettype none
module dxv_group_pick
   import dxv_pkg::*;
#(
   parameter int FIRST = 0,
   parameter int LAST = 9
) (
   input wire logic [DXV_NUM_ENTRY-1:0] pend,
   output logic hit,
   output logic [5:0] idx
);
   // Scan downward so the lowest priority number wins
   always_comb begin
      hit = 1'b0;
      idx = 6'h00;
      for (int i = LAST; i >= FIRST; i--) begin
         if (pend[i]) begin
            hit = 1'b1;
            idx = 6'(i);
         end
      end
   end
endmodule : dxv_group_pick
`default_nettype wire

// File: dxv_irq_chk.sv
// Assertion checker for the interrupt expansion unit, bound to its top
`timescale 1ns/100ps
`default_nettype none
module dxv_irq_chk
   import dxv_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic watchdog_timeout,
   input wire logic soft_irq_instruction,
   input wire logic [4:0] soft_irq_operand,
   input wire logic nmi_instruction,
   input wire logic trap_instruction,
   input wire logic emu_trap_req,
   input wire logic irq_disable_set,
   input wire logic irq_disable_clear,
   input wire logic core_ack,
   input wire logic [2:0] core_ack_line,
   input wire logic [DXV_NUM_LINE-1:0] core_line_mask,
   input wire logic core_reset_out,
   input wire logic global_irq_disable,
   input wire logic [DXV_NUM_LINE-1:0] core_line_req,
   input wire dxv_branch_s branch
);
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (reset);
   // Reset source or disable strobe would change the outcome, so exclude them
   logic calm;
   logic no_sw;
   assign calm = !watchdog_timeout && !core_reset_out && !irq_disable_set && !irq_disable_clear;
   assign no_sw = !soft_irq_instruction && !nmi_instruction && !trap_instruction && !emu_trap_req;
   property p_reset_vec;
      $rose(core_reset_out) |-> branch.valid && branch.cause == DXV_CAUSE_RESET
         && branch.addr == 16'h0000;
   endproperty
   a_reset_vec: assert property (p_reset_vec) else $error("reset branch wrong");
   property p_reset_hold;
      core_reset_out ##1 core_reset_out |-> global_irq_disable
         && (!branch.valid || branch.cause == DXV_CAUSE_RESET);
   endproperty
   a_reset_hold: assert property (p_reset_hold) else $error("request passed reset");
   property p_soft;
      soft_irq_instruction && !emu_trap_req && !nmi_instruction && calm |=> branch.valid
         && branch.cause == DXV_CAUSE_SOFT && global_irq_disable
         && branch.addr == {10'h000, $past(soft_irq_operand), 1'b0};
   endproperty
   a_soft: assert property (p_soft) else $error("soft branch wrong");
   property p_nmi;
      nmi_instruction && !emu_trap_req && calm |=> branch.valid && global_irq_disable
         && branch.cause == DXV_CAUSE_NMI && branch.addr == 16'h0024;
   endproperty
   a_nmi: assert property (p_nmi) else $error("nmi branch wrong");
   property p_trap;
      trap_instruction && !soft_irq_instruction && !nmi_instruction && !emu_trap_req && calm
         |=> branch.cause == DXV_CAUSE_TRAP && branch.addr == 16'h0022
         && $stable(global_irq_disable);
   endproperty
   a_trap: assert property (p_trap) else $error("trap branch wrong");
   property p_emu;
      emu_trap_req && calm |=> branch.valid && global_irq_disable
         && branch.cause == DXV_CAUSE_EMU && branch.addr == 16'h0026;
   endproperty
   a_emu: assert property (p_emu) else $error("emulator branch wrong");
   property p_line;
      core_ack && core_ack_line inside {[1:6]} && no_sw && calm |=> branch.valid
         && branch.cause == DXV_CAUSE_LINE && branch.addr == {12'h000, $past(core_ack_line), 1'b0};
   endproperty
   a_line: assert property (p_line) else $error("line vector wrong");
   property p_gate;
      core_line_req != '0 |-> !global_irq_disable && (core_line_req & ~core_line_mask) == '0;
   endproperty
   a_gate: assert property (p_gate) else $error("masked line requested");
   // Main scenarios reached
   c_reset: cover property ($rose(core_reset_out));
   c_ack: cover property (core_ack && core_line_req != '0);
   c_trap: cover property (trap_instruction && calm);
endmodule : dxv_irq_chk
bind dxv_irq_expansion_unit dxv_irq_chk u_chk (
   .clk, .reset, .watchdog_timeout, .soft_irq_instruction, .soft_irq_operand,
   .nmi_instruction, .trap_instruction, .emu_trap_req, .irq_disable_set, .irq_disable_clear,
   .core_ack, .core_ack_line, .core_line_mask, .core_reset_out, .global_irq_disable,
   .core_line_req, .branch
);
`default_nettype wire

// File: dxv_irq_expansion_unit.sv
// Reset, software interrupt and peripheral interrupt expansion to six core lines
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// R1: Pin or watchdog reset overrides all, vector zero
// R2: Maskable interrupts disabled after reset until enabled
// R3: Pin interrupts gated by enable and line mask
// R4: Peripheral events gated by enable and line mask
// R5: Software interrupt branches to operand, sets disable
// R6: Nonmaskable instruction branches 24h, sets disable
// R7: Trap branches 22h, leaves disable untouched
// R8: Emulator trap nonmaskable, vector 26h, priority two
// R9: All requests share six lines, unique vectors
// R10: Lines one to three vector 2h, 4h, 6h
// R11: Lines four to six vector 8h, Ah, Ch
// R12: Converter selectable line one or five, vector 4h
// R13: Serial receive/transmit selectable, vectors 6h, 7h
// R14: Network mailbox/error selectable, vectors 40h, 41h
// R15: External pins selectable line one or six
// R16: First timer events on line two, 27h-2Ah
// R17: Second timer events on line three, 2Bh-2Eh
// R18: Third timer events on line two, 2Fh-32h
// R19: Fourth timer events on line three, 39h-3Ch
// R20: Empty group acknowledge returns phantom vector zero
// R21: Lowest priority number wins, its flag cleared
// R22: Capture units on line four, 33h-38h
module dxv_irq_expansion_unit
   import dxv_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic reset_pin_n,
   input wire logic watchdog_timeout,
   input wire logic ext_pin_irq_a,
   input wire logic ext_pin_irq_b,
   input wire logic power_protect_irq_a_n,
   input wire logic power_protect_irq_b_n,
   input wire logic [DXV_NUM_EVENT-1:0] periph_event,
   input wire logic [DXV_NUM_EVENT-1:0] periph_enable,
   input wire logic [DXV_NUM_SEL-1:0] low_prio_sel,
   input wire logic [DXV_NUM_LINE-1:0] core_line_mask,
   input wire logic soft_irq_instruction,
   input wire logic [4:0] soft_irq_operand,
   input wire logic nmi_instruction,
   input wire logic trap_instruction,
   input wire logic emu_trap_req,
   input wire logic irq_disable_set,
   input wire logic irq_disable_clear,
   input wire logic core_ack,
   input wire logic [2:0] core_ack_line,
   output logic core_reset_out,
   output logic global_irq_disable,
   output logic [DXV_NUM_LINE-1:0] core_line_req,
   output logic [DXV_NUM_FLAG-1:0] periph_request_flags,
   output logic [DXV_NUM_FLAG-1:0] periph_ack_flags,
   output dxv_branch_s branch
);
   logic [DXV_NUM_PIN-1:0] pin_raw;
   logic [DXV_NUM_PIN-1:0] pin_level;
   logic [DXV_NUM_PIN-1:0] pin_rise;
   logic [DXV_NUM_EVENT-1:0] event_all;
   logic [DXV_NUM_ENTRY-1:0] flags_q;
   logic [DXV_NUM_ENTRY-1:0] flags_d;
   logic [DXV_NUM_ENTRY-1:0] flag_set;
   logic [DXV_NUM_ENTRY-1:0] flag_clr;
   logic [DXV_NUM_ENTRY-1:0] entry_en;
   logic [DXV_NUM_ENTRY-1:0] pend;
   logic [DXV_NUM_LINE-1:0] grp_hit;
   logic [5:0] grp_idx [DXV_NUM_LINE];
   logic [DXV_NUM_LINE-1:0] line_pend;
   logic global_irq_disable_q;
   logic global_irq_disable_d;
   logic rst_req;
   logic rst_req_q;
   logic rst_rise;
   logic ack_ok;
   logic [2:0] ack_grp;
   logic ack_hit;
   logic [5:0] ack_idx;
   logic take_soft;
   logic take_nmi;
   logic take_trap;
   logic take_emu;
   logic take_ack;
   logic global_irq_disable_raise;
   dxv_branch_s branch_q;
   dxv_branch_s branch_d;
   logic [DXV_NUM_FLAG-1:0] ack_flags_q;
   logic [DXV_NUM_FLAG-1:0] ack_flags_d;
   logic [DXV_NUM_FLAG-1:0] req_flags;

   // Pins: protection pins are active low, inverted ahead of the first stage
   assign pin_raw = {~reset_pin_n, ext_pin_irq_b, ext_pin_irq_a,
                     ~power_protect_irq_b_n, ~power_protect_irq_a_n};

   dxv_pin_sync #(
      .WIDTH(DXV_NUM_PIN)
   ) u_pin_sync (
      .clk(clk),
      .reset(reset),
      .pin(pin_raw),
      .level(pin_level),
      .rise(pin_rise)
   );

   // Pin edges join the peripheral event word at their fixed positions
   always_comb begin
      event_all = periph_event;
      event_all[DXV_EV_PDP_A] = periph_event[DXV_EV_PDP_A] | pin_rise[0];
      event_all[DXV_EV_PDP_B] = periph_event[DXV_EV_PDP_B] | pin_rise[1];
      event_all[DXV_EV_EXT_A] = periph_event[DXV_EV_EXT_A] | pin_rise[2];
      event_all[DXV_EV_EXT_B] = periph_event[DXV_EV_EXT_B] | pin_rise[3];
   end

   // Reset request from the filtered pin or the watchdog
   // R1: reset sources combined
   assign rst_req = pin_level[4] | watchdog_timeout;
   assign rst_rise = rst_req & ~rst_req_q;

   // Route each event to its high or low priority entry
   // R12: converter mode select
   // R13: serial mode select
   // R14: network mode select
   // R15: pin mode select
   always_comb begin
      flag_set = '0;
      for (int e = 0; e < DXV_NUM_EVENT; e++) begin
         if (e >= DXV_SEL_BASE && e < DXV_SEL_BASE + DXV_NUM_SEL) begin
            if (low_prio_sel[e - DXV_SEL_BASE]) begin
               flag_set[DXV_LO_ENTRY[e - DXV_SEL_BASE]] = event_all[e];
            end else begin
               flag_set[e] = event_all[e];
            end
         end else begin
            flag_set[e] = event_all[e];
         end
      end
   end

   // Per-entry enable taken from the event that feeds it
   // R3: pin dedicated enables
   // R4: peripheral event enables
   always_comb begin
      entry_en = '0;
      for (int k = 0; k < DXV_NUM_ENTRY; k++) begin
         entry_en[k] = periph_enable[dxv_event_of(k)];
      end
   end
   assign pend = flags_q & entry_en;

   // One pick per core line over its slice of the table
   // R9: six shared groups
   // R16: first timer slice on line two
   // R17: second timer slice on line three
   // R18: third timer slice on line two
   // R19: fourth timer slice on line three
   // R22: capture slice on line four
   for (genvar g = 0; g < DXV_NUM_LINE; g++) begin : g_grp
      dxv_group_pick #(
         .FIRST(DXV_GRP_FIRST[g]),
         .LAST(DXV_GRP_LAST[g])
      ) u_pick (
         .pend(pend),
         .hit(grp_hit[g]),
         .idx(grp_idx[g])
      );
   end

   // Core line requests: pending, unmasked at the line, not globally disabled
   // R3: line mask on pins
   // R4: line mask on peripherals
   // R2: held off while disabled
   assign line_pend = grp_hit & core_line_mask;
   assign core_line_req = global_irq_disable_q ? '0 : line_pend;

   // Acknowledge decode; lines are numbered one to six
   assign ack_ok = (core_ack_line >= 3'h1) && (core_ack_line <= 3'h6);
   assign ack_grp = ack_ok ? core_ack_line - 3'h1 : 3'h0;
   assign ack_hit = grp_hit[ack_grp];
   assign ack_idx = grp_idx[ack_grp];

   // Arbitration among requests to branch, reset beyond it
   // R8: emulator trap ahead of the rest
   assign take_emu = ~rst_req & emu_trap_req;
   assign take_nmi = ~rst_req & ~emu_trap_req & nmi_instruction;
   assign take_soft = ~rst_req & ~emu_trap_req & ~nmi_instruction & soft_irq_instruction;
   assign take_trap = ~rst_req & ~emu_trap_req & ~nmi_instruction & ~soft_irq_instruction
                      & trap_instruction;
   assign take_ack = ~rst_req & ~emu_trap_req & ~nmi_instruction & ~soft_irq_instruction
                     & ~trap_instruction & core_ack & ack_ok;

   // Flag clear on acknowledge of the winner; a new event the same cycle wins
   // R21: winner flag cleared
   always_comb begin
      flag_clr = '0;
      if (take_ack && ack_hit) begin
         flag_clr[ack_idx] = 1'b1;
      end
   end
   assign flags_d = rst_req ? DXV_FLAGS_RST : ((flags_q & ~flag_clr) | flag_set);

   // Global disable: raised by taken interrupts, trap leaves it alone
   // R5: soft instruction sets disable
   // R6: nonmaskable instruction sets disable
   // R7: trap does not set disable
   assign global_irq_disable_raise = take_emu | take_nmi | take_soft | take_ack | irq_disable_set;
   // R2: disabled from reset until cleared
   assign global_irq_disable_d = rst_req ? DXV_GLOBAL_IRQ_DISABLE_RST : (global_irq_disable_raise | (global_irq_disable_q & ~irq_disable_clear));

   // Branch answer to the core
   always_comb begin
      branch_d = '0;
      branch_d.cause = DXV_CAUSE_NONE;
      branch_d.periph_vector_code = DXV_NONE_PIV;
      if (rst_rise) begin
         // R1: reset vector, ahead of all else
         branch_d.valid = 1'b1;
         branch_d.cause = DXV_CAUSE_RESET;
         branch_d.addr = DXV_RESET_VEC;
      end else if (take_emu) begin
         // R8: emulator trap vector
         branch_d.valid = 1'b1;
         branch_d.cause = DXV_CAUSE_EMU;
         branch_d.addr = DXV_EMU_VEC;
      end else if (take_nmi) begin
         // R6: fixed nonmaskable vector
         branch_d.valid = 1'b1;
         branch_d.cause = DXV_CAUSE_NMI;
         branch_d.addr = DXV_NMI_VEC;
      end else if (take_soft) begin
         // R5: operand names the vector word
         branch_d.valid = 1'b1;
         branch_d.cause = DXV_CAUSE_SOFT;
         branch_d.addr = {10'h000, soft_irq_operand, 1'b0};
      end else if (take_trap) begin
         // R7: fixed trap vector
         branch_d.valid = 1'b1;
         branch_d.cause = DXV_CAUSE_TRAP;
         branch_d.addr = DXV_TRAP_VEC;
      end else if (take_ack) begin
         // R10: lines one to three vectors
         // R11: lines four to six vectors
         branch_d.valid = 1'b1;
         branch_d.cause = DXV_CAUSE_LINE;
         branch_d.addr = DXV_LINE_VEC[ack_grp];
         // R20: phantom code on an empty group
         branch_d.periph_vector_code = ack_hit ? DXV_PIV[ack_idx] : DXV_PHANTOM_PIV;
      end
   end

   // Flag word view and acknowledge pulse in register-bit layout
   always_comb begin
      req_flags = '0;
      ack_flags_d = '0;
      for (int k = 0; k < DXV_NUM_ENTRY; k++) begin
         req_flags[DXV_FLAG_POS[k]] = flags_q[k];
         ack_flags_d[DXV_FLAG_POS[k]] = flag_clr[k];
      end
   end
   assign periph_request_flags = req_flags;

   // State registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         flags_q <= DXV_FLAGS_RST;
         global_irq_disable_q <= DXV_GLOBAL_IRQ_DISABLE_RST;
         rst_req_q <= 1'b0;
         branch_q <= '0;
         ack_flags_q <= '0;
      end else begin
         flags_q <= flags_d;
         global_irq_disable_q <= global_irq_disable_d;
         rst_req_q <= rst_req;
         branch_q <= branch_d;
         ack_flags_q <= ack_flags_d;
      end
   end

   // Outputs straight from flip-flops
   assign core_reset_out = rst_req_q;
   assign global_irq_disable = global_irq_disable_q;
   assign periph_ack_flags = ack_flags_q;
   assign branch = branch_q;

endmodule : dxv_irq_expansion_unit
`default_nettype wire

// File: dxv_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and rise pulse
`timescale 1ns/100ps
`default_nettype none
module dxv_pin_sync #(
   parameter int WIDTH = 5
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] level_q;
   logic [WIDTH-1:0] level_d;
   logic [WIDTH-1:0] agree;

   // Only the later two stages are compared; the first may be metastable
   assign agree = ~(s2_q ^ s3_q);
   assign level_d = (agree & s3_q) | (~agree & level_q);
   assign level = level_q;
   assign rise = level_d & ~level_q;

   // Shift chain and filtered level
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         level_q <= '0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         level_q <= level_d;
      end
   end
endmodule : dxv_pin_sync
`default_nettype wire

// File: dxv_pkg.sv
// Constants, tables and types for the interrupt expansion and vectoring unit
package dxv_pkg;

   // Sizes of the request tables
   localparam int DXV_NUM_ENTRY = 46;
   localparam int DXV_NUM_EVENT = 38;
   localparam int DXV_NUM_SEL = 8;
   localparam int DXV_NUM_LINE = 6;
   localparam int DXV_NUM_FLAG = 48;
   localparam int DXV_SEL_BASE = 2;
   localparam int DXV_NUM_PIN = 5;

   // Fixed vector locations
   localparam logic [15:0] DXV_RESET_VEC = 16'h0000;
   localparam logic [15:0] DXV_EMU_VEC = 16'h0026;
   localparam logic [15:0] DXV_NMI_VEC = 16'h0024;
   localparam logic [15:0] DXV_TRAP_VEC = 16'h0022;
   localparam logic [15:0] DXV_PHANTOM_PIV = 16'h0000;
   localparam logic [15:0] DXV_NONE_PIV = 16'h0000;

   // Values after reset
   localparam logic DXV_GLOBAL_IRQ_DISABLE_RST = 1'b1;
   localparam logic [DXV_NUM_ENTRY-1:0] DXV_FLAGS_RST = '0;

   // Core line vectors, line one first
   localparam logic [15:0] DXV_LINE_VEC [DXV_NUM_LINE] = '{
      16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000A, 16'h000C};

   // Entries are held in overall priority order; each line owns one slice
   localparam int DXV_GRP_FIRST [DXV_NUM_LINE] = '{0, 10, 24, 32, 38, 44};
   localparam int DXV_GRP_LAST [DXV_NUM_LINE] = '{9, 23, 31, 37, 43, 45};

   // Peripheral vector of each entry
   localparam logic [15:0] DXV_PIV [DXV_NUM_ENTRY] = '{
      16'h0020, 16'h0019, 16'h0004, 16'h0001, 16'h0011, 16'h0005, 16'h0006, 16'h0007,
      16'h0040, 16'h0041, 16'h0021, 16'h0022, 16'h0023, 16'h0027, 16'h0028, 16'h0029,
      16'h002A, 16'h0024, 16'h0025, 16'h0026, 16'h002F, 16'h0030, 16'h0031, 16'h0032,
      16'h002B, 16'h002C, 16'h002D, 16'h002E, 16'h0039, 16'h003A, 16'h003B, 16'h003C,
      16'h0033, 16'h0034, 16'h0035, 16'h0036, 16'h0037, 16'h0038, 16'h0005, 16'h0006,
      16'h0007, 16'h0040, 16'h0041, 16'h0004, 16'h0001, 16'h0011};

   // Position of each entry in the flag word: register times sixteen plus bit
   localparam logic [5:0] DXV_FLAG_POS [DXV_NUM_ENTRY] = '{
      6'h00, 6'h20, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06,
      6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E,
      6'h0F, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27,
      6'h10, 6'h11, 6'h12, 6'h13, 6'h28, 6'h29, 6'h2A, 6'h2B,
      6'h14, 6'h15, 6'h16, 6'h2C, 6'h2D, 6'h2E, 6'h17, 6'h18,
      6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h1E};

   // Low-priority entry of each selectable event, and the reverse map
   localparam int DXV_LO_ENTRY [DXV_NUM_SEL] = '{43, 44, 45, 38, 39, 40, 41, 42};
   localparam int DXV_LO_EVENT [DXV_NUM_SEL] = '{5, 6, 7, 8, 9, 2, 3, 4};

   // Event positions driven by the synchronised pins
   localparam int DXV_EV_PDP_A = 0;
   localparam int DXV_EV_PDP_B = 1;
   localparam int DXV_EV_EXT_A = 3;
   localparam int DXV_EV_EXT_B = 4;

   // Cause of a branch handed to the core
   typedef enum logic [2:0] {
      DXV_CAUSE_NONE,
      DXV_CAUSE_RESET,
      DXV_CAUSE_EMU,
      DXV_CAUSE_NMI,
      DXV_CAUSE_SOFT,
      DXV_CAUSE_TRAP,
      DXV_CAUSE_LINE
   } dxv_cause_e;

   typedef struct packed {
      logic valid;
      dxv_cause_e cause;
      logic [15:0] addr;
      logic [15:0] periph_vector_code;
   } dxv_branch_s;

   // Event feeding an entry, used by the enable gating only; set logic uses DXV_LO_ENTRY
   function automatic int dxv_event_of(input int entry);
      if (entry < DXV_NUM_EVENT) begin
         return entry;
      end
      return DXV_LO_EVENT[entry - DXV_NUM_EVENT];
   endfunction : dxv_event_of

endpackage : dxv_pkg

// File: test_dsp_interrupt_expansion_vectoring.sv
// Self-checking testbench for the interrupt expansion unit
`timescale 1ns/100ps
`default_nettype none
module test_dsp_interrupt_expansion_vectoring
   import dxv_pkg::*;
;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic reset_pin_n = 1'b1;
   logic watchdog_timeout = 1'b0;
   logic [3:0] pins = 4'h0;
   logic [5:0] sw = 6'h00;
   logic [4:0] soft_irq_operand = 5'h00;
   logic [DXV_NUM_EVENT-1:0] periph_event = '0;
   logic [DXV_NUM_EVENT-1:0] periph_enable = '1;
   logic [DXV_NUM_SEL-1:0] low_prio_sel = 8'h00;
   logic [DXV_NUM_LINE-1:0] core_line_mask = 6'h3F;
   logic core_ack, core_reset_out, global_irq_disable;
   logic [2:0] core_ack_line;
   logic [DXV_NUM_LINE-1:0] core_line_req;
   logic [DXV_NUM_FLAG-1:0] periph_request_flags, periph_ack_flags;
   dxv_branch_s branch;
   int errors = 0;
   int comparisons = 0;
   // 50 MHz clock
   always #10 clk = ~clk;
   dxv_core_model core (.clk, .core_ack, .core_ack_line);
   // Software strobes share one vector so a case can raise several at once
   dxv_irq_expansion_unit dut (
      .clk, .reset, .reset_pin_n, .watchdog_timeout, .periph_event, .periph_enable,
      .ext_pin_irq_a(pins[0]), .ext_pin_irq_b(pins[1]),
      .power_protect_irq_a_n(~pins[2]), .power_protect_irq_b_n(~pins[3]),
      .low_prio_sel, .core_line_mask, .soft_irq_instruction(sw[0]), .soft_irq_operand,
      .nmi_instruction(sw[1]), .trap_instruction(sw[2]), .emu_trap_req(sw[3]),
      .irq_disable_set(sw[4]), .irq_disable_clear(sw[5]), .core_ack, .core_ack_line,
      .core_reset_out, .global_irq_disable, .core_line_req, .periph_request_flags,
      .periph_ack_flags, .branch
   );
   task automatic tick;
      @(posedge clk);
      #1;
   endtask : tick
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_br(input dxv_cause_e c, input logic [15:0] a, input logic [15:0] p);
      chk(48'(branch), 48'({1'b1, c, a, p}));
   endtask : chk_br
   task automatic print_verdict;
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict
   // A bound that ran out ends the run at once
   task automatic guard(input logic ok);
      chk(48'(ok), 48'h1);
      if (ok !== 1'b1) begin
         print_verdict();
      end
   endtask : guard
   task automatic pulse(input logic [5:0] req, input logic [4:0] op);
      tick;
      sw = req;
      soft_irq_operand = op;
      tick;
      sw = 6'h00;
   endtask : pulse
   task automatic fire(input int ev);
      tick;
      periph_event = 38'h1 << ev;
      tick;
      periph_event = '0;
   endtask : fire
   task automatic wait_rst(input logic lvl);
      for (int i = 0; i < 12 && core_reset_out !== lvl; i++) begin
         tick;
      end
      guard(core_reset_out === lvl);
   endtask : wait_rst
   task automatic t_reset;
      chk(48'(global_irq_disable), 48'h1);
      fire(13);
      chk(48'(core_line_req), 48'h0);
      chk(periph_request_flags, 48'h1 << 12);
      tick;
      watchdog_timeout = 1'b1;
      tick;
      watchdog_timeout = 1'b0;
      wait_rst(1'b1);
      chk_br(DXV_CAUSE_RESET, 16'h0000, 16'h0000);
      wait_rst(1'b0);
      chk(periph_request_flags, 48'h0);
      reset_pin_n = 1'b0;
      wait_rst(1'b1);
      chk_br(DXV_CAUSE_RESET, 16'h0000, 16'h0000);
      reset_pin_n = 1'b1;
      wait_rst(1'b0);
      chk(48'(global_irq_disable), 48'h1);
      $display("t_reset done");
   endtask : t_reset
   task automatic sw_case(input logic [5:0] req, input logic [4:0] op, input dxv_cause_e c,
      input logic [15:0] a, input logic dis);
      pulse(6'h20, 5'h00);
      pulse(req, op);
      chk_br(c, a, 16'h0000);
      chk(48'(global_irq_disable), 48'(dis));
   endtask : sw_case
   task automatic t_sw;
      sw_case(6'h01, 5'h05, DXV_CAUSE_SOFT, 16'h000A, 1'b1);
      sw_case(6'h01, 5'h1F, DXV_CAUSE_SOFT, 16'h003E, 1'b1);
      sw_case(6'h02, 5'h00, DXV_CAUSE_NMI, 16'h0024, 1'b1);
      sw_case(6'h04, 5'h00, DXV_CAUSE_TRAP, 16'h0022, 1'b0);
      sw_case(6'h05, 5'h03, DXV_CAUSE_SOFT, 16'h0006, 1'b1);
      sw_case(6'h0E, 5'h00, DXV_CAUSE_EMU, 16'h0026, 1'b1);
      $display("t_sw done");
   endtask : t_sw
   // Line vector is twice the line number
   task automatic line_case(input int ev, input logic [7:0] sel, input logic [2:0] line,
      input logic [15:0] periph_vector_code, input int flag);
      low_prio_sel = sel;
      pulse(6'h20, 5'h00);
      fire(ev);
      chk(48'(core_line_req), 48'h1 << (line - 3'h1));
      chk(periph_request_flags, 48'h1 << flag);
      core.ack(line, 0);
      chk_br(DXV_CAUSE_LINE, {12'h000, line, 1'b0}, periph_vector_code);
      chk(periph_ack_flags, 48'h1 << flag);
      chk(48'(core_line_req), 48'h0);
   endtask : line_case
   task automatic t_lines;
      line_case(0, 8'h00, 3'h1, 16'h0020, 0);
      line_case(2, 8'h00, 3'h1, 16'h0004, 1);
      line_case(2, 8'h01, 3'h5, 16'h0004, 28);
      line_case(6, 8'h10, 3'h5, 16'h0006, 24);
      line_case(7, 8'h00, 3'h1, 16'h0007, 6);
      line_case(8, 8'h00, 3'h1, 16'h0040, 7);
      line_case(9, 8'h80, 3'h5, 16'h0041, 27);
      line_case(3, 8'h00, 3'h1, 16'h0001, 2);
      line_case(4, 8'h04, 3'h6, 16'h0011, 30);
      line_case(23, 8'h00, 3'h2, 16'h0032, 39);
      line_case(24, 8'h00, 3'h3, 16'h002B, 16);
      line_case(31, 8'h00, 3'h3, 16'h003C, 43);
      line_case(32, 8'h00, 3'h4, 16'h0033, 20);
      line_case(37, 8'h00, 3'h4, 16'h0038, 46);
      low_prio_sel = 8'h00;
      $display("t_lines done");
   endtask : t_lines
   // Five events at once drain in order; the extra acknowledge finds nothing
   task automatic t_prio;
      logic [15:0] pv [6] = '{16'h0027, 16'h0028, 16'h0029, 16'h002A, 16'h002F, 16'h0000};
      pulse(6'h20, 5'h00);
      tick;
      periph_event = 38'h11_E000;
      tick;
      periph_event = '0;
      for (int i = 0; i < 6; i++) begin
         core.ack(3'h2, i);
         chk_br(DXV_CAUSE_LINE, 16'h0004, pv[i]);
      end
      chk(periph_ack_flags, 48'h0);
      core.ack(3'h7, 0);
      chk(48'(branch), 48'h0);
      $display("t_prio done");
   endtask : t_prio
   task automatic t_gate;
      periph_enable[13] = 1'b0;
      pulse(6'h20, 5'h00);
      fire(13);
      chk(48'(core_line_req), 48'h0);
      periph_enable[13] = 1'b1;
      core_line_mask = 6'h3D;
      tick;
      chk(48'(core_line_req), 48'h0);
      core_line_mask = 6'h3F;
      tick;
      chk(48'(core_line_req), 48'h2);
      pulse(6'h10, 5'h00);
      chk(48'(core_line_req), 48'h0);
      core.ack(3'h2, 1);
      chk_br(DXV_CAUSE_LINE, 16'h0004, 16'h0027);
      $display("t_gate done");
   endtask : t_gate
   // Pins need their enable; each has its own vector on line one
   task automatic t_pins;
      logic [15:0] pv [4] = '{16'h0001, 16'h0011, 16'h0020, 16'h0019};
      periph_enable[3] = 1'b0;
      pulse(6'h20, 5'h00);
      pins = 4'h1;
      repeat (8) tick;
      chk(48'(core_line_req), 48'h0);
      chk(periph_request_flags, 48'h4);
      for (int i = 0; i < 4; i++) begin
         periph_enable[3] = 1'b1;
         pins = 4'h1 << i;
         pulse(6'h20, 5'h00);
         for (int k = 0; k < 12 && core_line_req !== 6'h01; k++) begin
            tick;
         end
         guard(core_line_req === 6'h01);
         core.ack(3'h1, 0);
         chk_br(DXV_CAUSE_LINE, 16'h0002, pv[i]);
      end
      pins = 4'h0;
      $display("t_pins done");
   endtask : t_pins
   initial begin
      repeat (16) @(posedge clk);
      #1;
      reset = 1'b0;
      t_reset();
      t_sw();
      t_lines();
      t_prio();
      t_gate();
      t_pins();
      print_verdict();
   end
endmodule : test_dsp_interrupt_expansion_vectoring
`default_nettype wire
